// *** hw/acs_map.svh ***
// Register indices, field positions, reset values and codes of the sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Register indices; the byte address is four times the index
`define ACS_IDX_CONV_A 8'h00
`define ACS_IDX_CONV_B 8'h01
`define ACS_IDX_REFERENCE 8'h02
`define ACS_IDX_EVCTRL 8'h03
`define ACS_IDX_PRESC 8'h04
`define ACS_IDX_STATUS 8'h05
`define ACS_IDX_FLAGS 8'h06
`define ACS_IDX_CAL 8'h0C
`define ACS_IDX_RESULT 8'h10
`define ACS_IDX_CMP 8'h18
`define ACS_IDX_CHCTRL 8'h20
`define ACS_IDX_CMPCTRL 8'h21
// Field positions
`define ACS_B_ENABLE 0
`define ACS_B_FLUSH 1
`define ACS_B_START 2
`define ACS_B_CONT 3
`define ACS_B_SIGNED 4
`define ACS_F_FMT 2:1
`define ACS_F_REFSRC 6:4
`define ACS_B_BANDGAP 1
`define ACS_B_THERMAL 0
`define ACS_F_EVSEL 5:3
`define ACS_B_EVEN 0
`define ACS_B_CHSTART 7
`define ACS_F_GAIN 4:2
`define ACS_B_DONE 0
`define ACS_B_CMPEN 0
`define ACS_B_CMPABOVE 1
// Reset values
`define ACS_RST_CONV_B 8'h00
`define ACS_RST_REFERENCE 8'h00
`define ACS_RST_PRESC 3'h0
`define ACS_RST_CAL 12'h000
`define ACS_RST_CMP 16'h0000
// Result format codes
`define ACS_FMT_R12 2'h0
`define ACS_FMT_RSVD 2'h1
`define ACS_FMT_R8 2'h2
`define ACS_FMT_L12 2'h3
// Reference codes
`define ACS_INTERNAL_ONE_VOLT_REF 3'h0
`define ACS_INTERNAL_SUPPLY_SCALED_REF 3'h1
`define ACS_EXTERNAL_REFERENCE_A 3'h2
`define ACS_EXTERNAL_REFERENCE_B 3'h3
// Timing: peripheral cycles per half converter clock at code 000 (divide by 4)
`define ACS_HALF_BASE 9'h002
// Converter clock cycles outside the bit phase
`define ACS_BASE_CYCLES 1
`endif

// *** hw/acs_pkg.sv ***
// Types of the conversion sequencer
package acs_pkg;
	typedef enum logic [4:0] {
		ACS_IDLE = 5'h01,
		ACS_GAIN = 5'h02,
		ACS_SAMPLE = 5'h04,
		ACS_CONVERT = 5'h08,
		ACS_FINISH = 5'h10
	} acs_phase_e;
	typedef struct packed {
		acs_phase_e phase;
		logic enable;
		logic start_pend;
		logic [7:0] conv_b;
		logic [7:0] ref_ctl;
		logic [2:0] ref_out;
		logic ev_en;
		logic [2:0] ev_sel;
		logic [2:0] presc;
		logic [2:0] gain_code;
		logic [11:0] cal;
		logic [15:0] cmp;
		logic cmp_en;
		logic cmp_above;
		logic [15:0] result;
		logic done_flag;
		logic busy;
		logic [8:0] pcnt;
		logic adc_clk;
		logic [2:0] hcnt;
		logic [3:0] bits_left;
		logic [11:0] code;
		logic [11:0] mask;
		logic [1:0] conv_fmt;
		logic conv_signed;
		logic sample;
		logic gain_sample;
		logic event_pulse;
		logic dp_act;
		logic dp_write;
		logic [7:0] dp_idx;
		logic hready;
		logic [31:0] hrdata;
	} acs_state_s;
endpackage

// *** hw/acs_sequencer.sv ***
// Conversion sequencer of a successive-approximation converter, AHB-Lite slave
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_sequencer (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out,
	input wire logic [3:0] event_lines_in,
	input wire logic irq_ack_in,
	input wire logic comparator_in,
	output logic irq_out,
	output logic event_out,
	output logic adc_clk_out,
	output logic sample_out,
	output logic gain_sample_out,
	output logic [11:0] sar_trial_out,
	output logic [2:0] ref_select_out,
	output logic bandgap_enable_out,
	output logic thermal_sensor_enable_out,
	output logic busy_out
);

	acs_pkg::acs_state_s s;
	acs_pkg::acs_state_s n;
	logic accept;
	logic wr;
	logic [31:0] rd;
	logic wr_flush;
	logic wr_start;
	logic wr_clr;
	logic ev_hit;
	logic [8:0] half_m1;
	logic tick;
	logic rise;
	logic go;
	logic [1:0] gcyc;
	logic [1:0] fmt;
	logic [15:0] res;
	logic hit;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [1:0] gain_cycles(input logic [2:0] g);
		case (g)
			3'h1, 3'h2: gain_cycles = 2'h1;
			3'h3, 3'h4: gain_cycles = 2'h2;
			3'h5, 3'h6: gain_cycles = 2'h3;
			default: gain_cycles = 2'h0;
		endcase
	endfunction

	function automatic logic [15:0] format_result(input logic [11:0] c,
		input logic [1:0] f, input logic sg);
		case (f)
			`ACS_FMT_R8: format_result = {{8{sg & c[11]}}, c[11:4]};
			`ACS_FMT_L12: format_result = {c, 4'h0};
			default: format_result = {{4{sg & c[11]}}, c};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	always_comb begin
		rd = 32'h0000_0000;
		case (s.dp_idx)
			`ACS_IDX_CONV_A: begin
				rd[`ACS_B_START] = s.start_pend;
				rd[`ACS_B_ENABLE] = s.enable;
			end
			`ACS_IDX_CONV_B: rd[7:0] = s.conv_b;
			`ACS_IDX_REFERENCE: rd[7:0] = s.ref_ctl;
			`ACS_IDX_EVCTRL: begin
				rd[`ACS_F_EVSEL] = s.ev_sel;
				rd[`ACS_B_EVEN] = s.ev_en;
			end
			`ACS_IDX_PRESC: rd[2:0] = s.presc;
			`ACS_IDX_STATUS: begin
				rd[4:0] = s.phase;
				rd[8] = s.adc_clk;
			end
			`ACS_IDX_FLAGS: rd[`ACS_B_DONE] = s.done_flag;
			`ACS_IDX_CAL: rd[11:0] = s.cal;
			`ACS_IDX_RESULT: rd[15:0] = s.result;
			`ACS_IDX_CMP: rd[15:0] = s.cmp;
			`ACS_IDX_CHCTRL: begin
				rd[`ACS_B_CHSTART] = s.start_pend;
				rd[`ACS_F_GAIN] = s.gain_code;
			end
			`ACS_IDX_CMPCTRL: begin
				rd[`ACS_B_CMPEN] = s.cmp_en;
				rd[`ACS_B_CMPABOVE] = s.cmp_above;
			end
			default: rd = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = s;
		n.event_pulse = 1'b0;
		wr_flush = 1'b0;
		wr_start = 1'b0;
		wr_clr = 1'b0;
		// Bus: address phase, one wait state, then data phase
		accept = hsel_in & htrans_in[1] & s.hready;
		wr = s.dp_act & s.dp_write;
		if (accept) begin
			n.dp_act = 1'b1;
			n.dp_write = hwrite_in;
			// Unmapped upper addresses fall on an index that reads zero
			if (|haddr_in[31:10]) begin
				n.dp_idx = 8'hFF;
			end else begin
				n.dp_idx = haddr_in[9:2];
			end
			n.hready = 1'b0;
		end else if (s.dp_act) begin
			n.dp_act = 1'b0;
			n.hready = 1'b1;
			if (!s.dp_write) begin
				n.hrdata = rd;
			end
		end
		if (wr) begin
			case (s.dp_idx)
				`ACS_IDX_CONV_A: begin
					n.enable = hwdata_in[`ACS_B_ENABLE];
					wr_flush = hwdata_in[`ACS_B_FLUSH];
					wr_start = hwdata_in[`ACS_B_START];
				end
				`ACS_IDX_CONV_B: begin
					n.conv_b = hwdata_in[7:0] & 8'h1E;
				end
				`ACS_IDX_REFERENCE: begin
					// source enables kept with reference field
					n.ref_ctl = hwdata_in[7:0] & 8'h73;
					// only four valid sources, else 1 V internal
					if (hwdata_in[6]) begin
						n.ref_out = `ACS_INTERNAL_ONE_VOLT_REF;
					end else begin
						n.ref_out = hwdata_in[`ACS_F_REFSRC];
					end
				end
				`ACS_IDX_EVCTRL: begin
					n.ev_sel = hwdata_in[`ACS_F_EVSEL];
					n.ev_en = hwdata_in[`ACS_B_EVEN];
				end
				`ACS_IDX_PRESC: n.presc = hwdata_in[2:0];
				`ACS_IDX_FLAGS: wr_clr = hwdata_in[`ACS_B_DONE];
				`ACS_IDX_CAL: n.cal = hwdata_in[11:0];
				`ACS_IDX_CMP: n.cmp = hwdata_in[15:0];
				`ACS_IDX_CHCTRL: begin
					// channel start aliases the single start bit
					wr_start = hwdata_in[`ACS_B_CHSTART];
					n.gain_code = hwdata_in[`ACS_F_GAIN];
				end
				`ACS_IDX_CMPCTRL: begin
					n.cmp_en = hwdata_in[`ACS_B_CMPEN];
					n.cmp_above = hwdata_in[`ACS_B_CMPABOVE];
				end
				default: n.enable = n.enable;
			endcase
		end
		ev_hit = s.ev_en & ~s.ev_sel[2] & event_lines_in[s.ev_sel[1:0]];

		// half period is 2 << code peripheral cycles, divide 4..512
		half_m1 = (`ACS_HALF_BASE << s.presc) - 9'h001;
		tick = s.enable & (s.pcnt == half_m1);
		rise = tick & ~s.adc_clk;
		go = s.start_pend | s.conv_b[`ACS_B_CONT];
		gcyc = gain_cycles(s.gain_code);
		// reserved format code behaves as right adjusted 12 bit
		if (s.conv_b[`ACS_F_FMT] == `ACS_FMT_RSVD) begin
			fmt = `ACS_FMT_R12;
		end else begin
			fmt = s.conv_b[`ACS_F_FMT];
		end
		res = format_result(s.code, s.conv_fmt, s.conv_signed);
		// Strict compare, in the number format of the running conversion
		if (s.cmp_above) begin
			if (s.conv_signed) begin
				hit = $signed(res) > $signed(s.cmp);
			end else begin
				hit = res > s.cmp;
			end
		end else begin
			if (s.conv_signed) begin
				hit = $signed(res) < $signed(s.cmp);
			end else begin
				hit = res < s.cmp;
			end
		end
		// Without compare every completion counts
		if (!s.cmp_en) begin
			hit = 1'b1;
		end

		// flush or disable aborts and holds clock at its start
		if (!s.enable || wr_flush) begin
			n.pcnt = 9'h000;
			n.adc_clk = 1'b0;
			n.phase = acs_pkg::ACS_IDLE;
			n.sample = 1'b0;
			n.gain_sample = 1'b0;
		end else begin
			if (tick) begin
				n.pcnt = 9'h000;
			end else begin
				n.pcnt = s.pcnt + 9'h001;
			end
			if (tick) begin
				n.adc_clk = ~s.adc_clk;
			end
			case (s.phase)
				acs_pkg::ACS_IDLE: begin
					// only an already registered request starts, on a rising edge
					if (rise && s.start_pend) begin
						n.phase = acs_pkg::ACS_SAMPLE;
					end
				end
				acs_pkg::ACS_GAIN: begin
					if (tick) begin
						// gain stage samples for the first half only
						n.gain_sample = 1'b0;
						if (s.hcnt == 3'h0) begin
							n.phase = acs_pkg::ACS_SAMPLE;
							n.sample = 1'b1;
						end else begin
							n.hcnt = s.hcnt - 3'h1;
						end
					end
				end
				acs_pkg::ACS_SAMPLE: begin
					if (tick) begin
						// sample half ends, MSB trial goes out
						n.sample = 1'b0;
						n.phase = acs_pkg::ACS_CONVERT;
						n.code = 12'h800;
						n.mask = 12'h800;
						if (s.conv_fmt == `ACS_FMT_R8) begin
							n.bits_left = 4'h7;
						end else begin
							n.bits_left = 4'hB;
						end
					end
				end
				acs_pkg::ACS_CONVERT: begin
					if (tick) begin
						// one bit resolved per half converter clock
						n.code = (comparator_in ? s.code : (s.code & ~s.mask)) |
							(s.mask >> 1);
						n.mask = s.mask >> 1;
						if (s.bits_left == 4'h0) begin
							n.phase = acs_pkg::ACS_FINISH;
						end else begin
							n.bits_left = s.bits_left - 4'h1;
						end
					end
				end
				acs_pkg::ACS_FINISH: begin
					if (tick) begin
						// result lands, with the flag and event only when hit is set
						n.result = res;
						n.event_pulse = hit;
						// next conversion only after this one ends
						if (go) begin
							n.phase = acs_pkg::ACS_SAMPLE;
						end else begin
							n.phase = acs_pkg::ACS_IDLE;
						end
					end
				end
				default: n.phase = acs_pkg::ACS_IDLE;
			endcase
			// Launch of a new conversion
			if (n.phase == acs_pkg::ACS_SAMPLE &&
				(s.phase == acs_pkg::ACS_IDLE || s.phase == acs_pkg::ACS_FINISH)) begin
				// start bit clears once conversion begins
				n.start_pend = 1'b0;
				n.conv_fmt = fmt;
				n.conv_signed = s.conv_b[`ACS_B_SIGNED];
				// gain adds two halves per extra cycle
				if (gcyc != 2'h0) begin
					n.phase = acs_pkg::ACS_GAIN;
					n.hcnt = {gcyc, 1'b0} - 3'h1;
					n.gain_sample = 1'b1;
				end else begin
					n.sample = 1'b1;
				end
			end
		end
		// start request set wins over the hardware clear
		if (wr_start || ev_hit) begin
			n.start_pend = 1'b1;
		end
		// vector or write-one clears, a new completion wins
		n.done_flag = (s.done_flag & ~(wr_clr | irq_ack_in)) | n.event_pulse;
		// Busy kept as its own flop so the output needs no gate
		n.busy = n.phase != acs_pkg::ACS_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.phase <= acs_pkg::ACS_IDLE;
			s.conv_b <= `ACS_RST_CONV_B;
			s.ref_ctl <= `ACS_RST_REFERENCE;
			s.ref_out <= `ACS_INTERNAL_ONE_VOLT_REF;
			s.presc <= `ACS_RST_PRESC;
			s.cal <= `ACS_RST_CAL;
			s.cmp <= `ACS_RST_CMP;
			s.hready <= 1'b1;
		end else if (ce_in) begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all but the tied-off response straight from the state register

	assign hreadyout_out = s.hready;
	assign hresp_out = 1'b0;
	assign hrdata_out = s.hrdata;
	assign irq_out = s.done_flag;
	assign event_out = s.event_pulse;
	assign adc_clk_out = s.adc_clk;
	assign sample_out = s.sample;
	assign gain_sample_out = s.gain_sample;
	assign sar_trial_out = s.code;
	assign ref_select_out = s.ref_out;
	// internal sources powered from their enable bits
	assign bandgap_enable_out = s.ref_ctl[`ACS_B_BANDGAP];
	assign thermal_sensor_enable_out = s.ref_ctl[`ACS_B_THERMAL];
	assign busy_out = s.busy;

endmodule

// *** verif/acs_analog_model.sv ***
// Analog input model: one fixed input level against the trial code
`timescale 1ns/1ps
module acs_analog_model (
	input wire logic [11:0] trial_in,
	input wire logic [11:0] level_in,
	output logic above_out
);
	// Level sits half a step above its code, so ties resolve upward
	assign above_out = level_in >= trial_in;
endmodule

// *** verif/acs_monitor.sv ***
// Port timing checker of the conversion sequencer
`timescale 1ns/1ps
module acs_monitor (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic irq_ack_in,
	input wire logic irq_out,
	input wire logic event_out,
	input wire logic adc_clk_out,
	input wire logic sample_out,
	input wire logic gain_sample_out,
	input wire logic [11:0] sar_trial_out,
	input wire logic [2:0] ref_select_out,
	input wire logic busy_out
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	a_bus_ready:
	assert property (hsel_in && htrans_in[1] && hreadyout_out && ce_in |=>
		!hreadyout_out ##1 hreadyout_out) else $error("bad wait state");
	a_resp_okay:
	assert property (hresp_out == 1'b0) else $error("response not okay");
	a_sample_edge:
	assert property ($rose(sample_out) |-> $rose(adc_clk_out)) else $error("sample off edge");
	a_start_sample:
	assert property ($rose(busy_out) |-> sample_out || gain_sample_out)
		else $error("start without sample");
	a_msb_first:
	assert property ($fell(sample_out) && busy_out |-> sar_trial_out == 12'h800)
		else $error("first trial not msb");
	a_event_pulse:
	assert property (event_out |=> !event_out) else $error("event too long");
	a_event_flag:
	assert property (event_out |-> irq_out) else $error("event without flag");
	a_idle_quiet:
	assert property (!busy_out |-> !sample_out && !gain_sample_out) else $error("sample while idle");
	a_ref_legal:
	assert property (ref_select_out[2] == 1'b0) else $error("undefined reference");
	a_ack_clear:
	assert property (irq_ack_in && !busy_out |=> !irq_out) else $error("ack kept flag");
	cover property ($rose(gain_sample_out));
	cover property ($rose(event_out));
	cover property (irq_ack_in && irq_out);
endmodule

// *** verif/acs_sequencer_test.sv ***
// Bench of the conversion sequencer
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer_test;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hsel = 1'b0;
	logic hwr = 1'b0;
	logic ack = 1'b0;
	logic irq_p = 1'b0;
	logic [1:0] htr = 2'h0;
	logic [31:0] ha = 32'h0;
	logic [31:0] hwd = 32'h0;
	logic [3:0] ev = 4'h0;
	logic rdy, resp, cmpl, irq, evo, aclk, smp, gsmp, bg, ts, busy;
	logic [31:0] hrd, rd_q;
	logic [11:0] trial;
	logic [2:0] refs;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int cnt = 0;
	int lat = 0;
	// Control b, prescaler, gain, compare control, result, latency
	logic [47:0] tbl [14] = '{48'h00_0_0_0_0A58_01C, 48'h04_0_0_0_00A5_014,
		48'h06_0_0_0_A580_01C, 48'h02_0_0_0_0A58_01C, 48'h10_0_0_0_FA58_01C,
		48'h14_0_0_0_FFA5_014, 48'h04_1_0_0_00A5_028, 48'h04_7_0_0_00A5_A00,
		48'h04_0_1_0_00A5_018, 48'h04_0_3_0_00A5_01C, 48'h04_0_5_0_00A5_020,
		48'h04_0_7_0_00A5_014, 48'h00_0_0_3_0A58_01C, 48'h00_0_0_1_0A58_000};
	acs_sequencer acs_sequencer_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.hsel_in(hsel), .haddr_in(ha), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2),
		.hwdata_in(hwd), .hreadyout_out(rdy), .hresp_out(resp), .hrdata_out(hrd),
		.event_lines_in(ev), .irq_ack_in(ack), .comparator_in(cmpl), .irq_out(irq),
		.event_out(evo), .adc_clk_out(aclk), .sample_out(smp), .gain_sample_out(gsmp),
		.sar_trial_out(trial), .ref_select_out(refs), .bandgap_enable_out(bg),
		.thermal_sensor_enable_out(ts), .busy_out(busy));
	acs_analog_model acs_analog_model_inst (.trial_in(trial), .level_in(12'hA58),
		.above_out(cmpl));
	always #5 clock_in = ~clock_in;
	// Busy cycles counted up to the rise of the flag
	always @(posedge clock_in) begin
		irq_p <= irq;
		if (irq && !irq_p) begin
			lat <= cnt;
		end
		cnt <= busy ? cnt + 1 : 0;
		cyc <= cyc + 1;
	end
	always @(posedge clock_in) begin
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: saw %h, want %h", $time, s, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clock_in);
		hsel <= 1'b1;
		htr <= 2'h2;
		hwr <= w;
		ha <= {22'h0, i, 2'h0};
		do @(posedge clock_in); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clock_in); while (rdy !== 1'b1);
		rd_q = hrd;
	endtask
	task wait_for(input logic on_irq, input logic lvl);
		int k;
		k = 0;
		while ((on_irq ? irq : busy) !== lvl && k < 4000) begin
			@(posedge clock_in);
			k++;
		end
	endtask
	task wait_done;
		wait_for(1'b0, 1'b1);
		wait_for(1'b0, 1'b0);
		repeat (2) @(posedge clock_in);
	endtask
	task conv(input logic [47:0] t);
		xfer(1'b1, `ACS_IDX_CONV_B, {24'h0, t[47:40]});
		xfer(1'b1, `ACS_IDX_PRESC, {29'h0, t[38:36]});
		xfer(1'b1, `ACS_IDX_CHCTRL, {27'h0, t[34:32], 2'h0});
		xfer(1'b1, `ACS_IDX_CMPCTRL, {30'h0, t[29:28]});
		xfer(1'b1, `ACS_IDX_CONV_A, 32'h5);
		wait_done();
		chk(irq, t[11:0] != 12'h0);
		if (t[11:0] != 12'h0) chk(lat, t[11:0]);
		xfer(1'b0, `ACS_IDX_RESULT, 32'h0);
		chk(rd_q, t[27:12]);
		xfer(1'b0, `ACS_IDX_CONV_A, 32'h0);
		chk(rd_q[2], 1'b0);
		xfer(1'b1, `ACS_IDX_FLAGS, 32'h1);
		chk(irq, 1'b0);
	endtask
	task test_done;
		$display("compared %0d, wrong %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		xfer(1'b0, `ACS_IDX_CONV_B, 32'h0);
		chk(rd_q, `ACS_RST_CONV_B);
		xfer(1'b0, `ACS_IDX_REFERENCE, 32'h0);
		chk(rd_q, `ACS_RST_REFERENCE);
		xfer(1'b0, 8'h3F, 32'h0);
		chk(rd_q, 32'h0);
		xfer(1'b1, `ACS_IDX_CAL, 32'h5A3);
		xfer(1'b0, `ACS_IDX_CAL, 32'h0);
		chk(rd_q, 32'h5A3);
		xfer(1'b1, `ACS_IDX_REFERENCE, 32'h23);
		chk({refs, bg, ts}, {`ACS_EXTERNAL_REFERENCE_A, 2'h3});
		xfer(1'b1, `ACS_IDX_REFERENCE, 32'h50);
		chk(refs, `ACS_INTERNAL_ONE_VOLT_REF);
		xfer(1'b1, `ACS_IDX_REFERENCE, 32'h10);
		chk(refs, `ACS_INTERNAL_SUPPLY_SCALED_REF);
		$display("test registers done");
		xfer(1'b1, `ACS_IDX_CMP, 32'h800);
		for (int i = 0; i < 14; i++) conv(tbl[i]);
		$display("test formats done");
		xfer(1'b1, `ACS_IDX_CMPCTRL, 32'h0);
		xfer(1'b1, `ACS_IDX_EVCTRL, 32'h9);
		ev <= 4'h2;
		@(posedge clock_in);
		ev <= 4'h0;
		wait_done();
		chk(lat, 28);
		ack <= 1'b1;
		@(posedge clock_in);
		ack <= 1'b0;
		@(posedge clock_in);
		chk(irq, 1'b0);
		xfer(1'b1, `ACS_IDX_EVCTRL, 32'h0);
		xfer(1'b1, `ACS_IDX_CONV_B, 32'h8);
		xfer(1'b1, `ACS_IDX_CONV_A, 32'h1);
		xfer(1'b1, `ACS_IDX_CHCTRL, 32'h80);
		// Let the next rising converter clock edge take the request
		repeat (4) @(posedge clock_in);
		xfer(1'b0, `ACS_IDX_CHCTRL, 32'h0);
		chk(rd_q[7], 1'b0);
		wait_for(1'b1, 1'b1);
		xfer(1'b1, `ACS_IDX_FLAGS, 32'h1);
		wait_for(1'b1, 1'b1);
		chk(irq, 1'b1);
		xfer(1'b1, `ACS_IDX_CONV_A, 32'h0);
		repeat (4) @(posedge clock_in);
		chk({busy, aclk}, 2'h0);
		$display("test triggers done");
		xfer(1'b1, `ACS_IDX_FLAGS, 32'h1);
		xfer(1'b1, `ACS_IDX_CONV_B, 32'h0);
		xfer(1'b1, `ACS_IDX_PRESC, 32'h3);
		xfer(1'b1, `ACS_IDX_CONV_A, 32'h5);
		wait_for(1'b0, 1'b1);
		repeat (20) @(posedge clock_in);
		xfer(1'b1, `ACS_IDX_CONV_A, 32'h7);
		repeat (3) @(posedge clock_in);
		chk({busy, irq}, 2'h0);
		wait_done();
		chk(lat, 224);
		xfer(1'b0, `ACS_IDX_RESULT, 32'h0);
		chk(rd_q, 32'hA58);
		$display("test flush done");
		test_done();
	end
endmodule
bind acs_sequencer acs_monitor acs_monitor_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.ce_in(ce_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .irq_ack_in(irq_ack_in), .irq_out(irq_out), .event_out(event_out),
	.adc_clk_out(adc_clk_out), .sample_out(sample_out), .gain_sample_out(gain_sample_out),
	.sar_trial_out(sar_trial_out), .ref_select_out(ref_select_out), .busy_out(busy_out));
